// ==== core/iog_top.sv ====
// Interrupt output gate: configuration, identity register and pin driver
`timescale 1ns/1ns
module iog_top #(
	parameter logic [15:0] DESIGN_ID = 16'h0a5c, // Arbitrary value
	parameter logic [15:0] DESIGN_REV = 16'h0001 // Arbitrary value
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SOFT_RST,
	input wire logic [7:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [31:0] WDATA,
	output logic [31:0] RDATA,
	input wire logic IRQ_LINE,
	input wire logic POWER_EVENT,
	output logic IRQ_O,
	output logic IRQ_OE
);
	iog_ctl_if ctl ();
	logic [7:0] interval_r;
	logic enable_r, polarity_r, type_r;
	logic [31:0] rdata_r;
	logic irq_o_r, irq_oe_r;

	iog_holdoff u_holdoff (
		.clk(CLK),
		.rst(SYS_RST),
		.ctl(ctl)
	);

	// Address decode and write fields; reserved bits ignored on write
	wire sel_cfg = (ADDR == iog_pkg::OFS_CFG);
	wire sel_id = (ADDR == iog_pkg::OFS_IDENT);
	wire wr_cfg = WR_EN & sel_cfg;
	wire [7:0] wr_interval = WDATA[iog_pkg::POS_INTERVAL +: 8];
	wire line_any = IRQ_LINE | POWER_EVENT;

	assign ctl.enable = enable_r;
	assign ctl.line = IRQ_LINE;
	assign ctl.interval = interval_r;
	assign ctl.restart = wr_cfg & WDATA[iog_pkg::POS_RESTART] & ~SOFT_RST;
	assign ctl.zero_wr = wr_cfg & (wr_interval == 8'h00);
	assign ctl.soft_rst = SOFT_RST;

	// Software reset clears enable and interval here, and the hold-off timer through ctl.soft_rst
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			interval_r <= iog_pkg::RST_INTERVAL;
			enable_r <= iog_pkg::RST_ENABLE;
		end else if (SOFT_RST) begin
			interval_r <= iog_pkg::RST_INTERVAL;
			enable_r <= iog_pkg::RST_ENABLE;
		end else if (wr_cfg) begin
			interval_r <= wr_interval;
			enable_r <= WDATA[iog_pkg::POS_ENABLE];
		end
	end

	// Pin shape bits are kept through software reset
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			polarity_r <= iog_pkg::RST_POLARITY;
			type_r <= iog_pkg::RST_TYPE;
		end else if (wr_cfg) begin
			polarity_r <= WDATA[iog_pkg::POS_POLARITY];
			type_r <= WDATA[iog_pkg::POS_TYPE];
		end
	end

	// Read mux; restart reads zero, reserved and unmapped read zero
	wire [31:0] cfg_word = {interval_r, 9'h000, 1'b0, ctl.active, line_any, 3'h0,
		enable_r, 3'h0, polarity_r, 3'h0, type_r};
	wire [31:0] id_word = {DESIGN_ID, DESIGN_REV};
	wire [31:0] rd_mux = sel_cfg ? cfg_word : (sel_id ? id_word : 32'h0000_0000);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_r <= 32'h0000_0000;
		end else if (RD_EN) begin
			rdata_r <= rd_mux;
		end
	end
	assign RDATA = rdata_r;

	// Power event goes straight to the pin, never held off
	wire pin_act = enable_r & (ctl.deliver | POWER_EVENT);
	// Open-drain only pulls low; push-pull drives both levels
	wire pin_o = type_r ? (polarity_r ? pin_act : ~pin_act) : 1'b0;
	wire pin_oe = type_r | pin_act;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_o_r <= 1'b0;
			irq_oe_r <= 1'b0;
		end else begin
			irq_o_r <= pin_o;
			irq_oe_r <= pin_oe;
		end
	end
	assign IRQ_O = irq_o_r;
	assign IRQ_OE = irq_oe_r;

	// Checks on the front end and pin
	AST_ENABLE_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
		(!enable_r && !type_r) |=> !IRQ_OE)
		else $error("pin driven while output disabled");
	AST_POWER_BYPASS: assert property (@(posedge CLK) disable iff (SYS_RST)
		(enable_r && POWER_EVENT && ctl.active) |=> IRQ_OE && (IRQ_O == (type_r & polarity_r)))
		else $error("power event held off");
	AST_OPEN_DRAIN_LOW: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(type_r) |-> !IRQ_O)
		else $error("open-drain pin driven high");
	AST_PUSH_PULL: assert property (@(posedge CLK) disable iff (SYS_RST)
		type_r |=> IRQ_OE)
		else $error("push-pull pin not driven");
	AST_IDENT: assert property (@(posedge CLK) disable iff (SYS_RST)
		(RD_EN && sel_id) |=> RDATA == {DESIGN_ID, DESIGN_REV})
		else $error("identity read wrong");
	AST_MASTER: assert property (@(posedge CLK) disable iff (SYS_RST)
		(RD_EN && sel_cfg) |=> RDATA[iog_pkg::POS_MASTER] == $past(line_any))
		else $error("master bit does not follow line");
	AST_SOFT_KEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
		(SOFT_RST && !wr_cfg) |=> $stable(polarity_r) && $stable(type_r) && !enable_r)
		else $error("soft reset touched pin shape");
	AST_COUNT_LIVE: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctl.active |-> ctl.count != 8'h00)
		else $error("hold-off running with empty count");
	COV_DELIVER: cover property (@(posedge CLK) disable iff (SYS_RST)
		pin_act && !POWER_EVENT ##1 IRQ_OE);
	COV_PP_HIGH: cover property (@(posedge CLK) disable iff (SYS_RST)
		type_r && polarity_r && IRQ_O);
endmodule // iog_top

// ==== core/iog_pkg.sv ====
// Package of constants for the interrupt output gate
package iog_pkg;
	localparam logic [7:0] OFS_IDENT = 8'h50;
	localparam logic [7:0] OFS_CFG = 8'h54;
	localparam int POS_INTERVAL = 24;
	localparam int POS_RESTART = 14;
	localparam int POS_ACTIVE = 13;
	localparam int POS_MASTER = 12;
	localparam int POS_ENABLE = 8;
	localparam int POS_POLARITY = 4;
	localparam int POS_TYPE = 0;
	localparam logic [7:0] RST_INTERVAL = 8'h00;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_POLARITY = 1'b0;
	localparam logic RST_TYPE = 1'b0;
	localparam int CLK_PERIOD_NS = 4;
	localparam int HOLDOFF_STEP_NS = 10000;
	// Least time, so round up to whole cycles
	localparam int TICK_CYC = (HOLDOFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
	typedef enum logic [1:0] {HO_IDLE, HO_DELIVER, HO_HOLD} iog_state_t;
endpackage

// ==== core/iog_ctl_if.sv ====
// Interface between the register front end and the hold-off timer
`timescale 1ns/1ns
interface iog_ctl_if;
	logic enable;
	logic line;
	logic [7:0] interval;
	logic restart;
	logic zero_wr;
	logic soft_rst;
	logic active;
	logic deliver;
	logic [7:0] count;
	modport tmr (input enable, line, interval, restart, zero_wr, soft_rst,
		output active, deliver, count);
	modport top (output enable, line, interval, restart, zero_wr, soft_rst,
		input active, deliver, count);
endinterface

// ==== core/iog_holdoff.sv ====
// Hold-off timer that paces delivery of IRQ_LINE only; the power event does not pass through it
`timescale 1ns/1ns
module iog_holdoff (
	input wire logic clk,
	input wire logic rst,
	iog_ctl_if.tmr ctl
);
	iog_pkg::iog_state_t state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [11:0] pre_r, pre_nxt;
	wire tick = (pre_r == iog_pkg::TICK_LAST);
	wire req = ctl.enable & ctl.line;
	wire nonzero = (ctl.interval != 8'h00);
	wire last = tick & (cnt_r <= 8'h01);

	// Next state; restart and zero write override the normal flow
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			iog_pkg::HO_IDLE: begin
				if (req) begin
					state_nxt = iog_pkg::HO_DELIVER;
				end
			end
			iog_pkg::HO_DELIVER: begin
				if (!req) begin
					// Interval length taken now, so a new value counts from here
					state_nxt = nonzero ? iog_pkg::HO_HOLD : iog_pkg::HO_IDLE;
					cnt_nxt = ctl.interval;
				end
			end
			iog_pkg::HO_HOLD: begin
				if (last) begin
					state_nxt = iog_pkg::HO_IDLE;
					cnt_nxt = 8'h00;
				end else if (tick) begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			default: begin
				state_nxt = iog_pkg::HO_IDLE;
				cnt_nxt = 8'h00;
			end
		endcase
		if (ctl.restart) begin
			state_nxt = nonzero ? iog_pkg::HO_HOLD : iog_pkg::HO_IDLE;
			cnt_nxt = nonzero ? ctl.interval : 8'h00;
		end
		if (ctl.zero_wr && state_nxt == iog_pkg::HO_HOLD) begin
			state_nxt = iog_pkg::HO_IDLE;
			cnt_nxt = 8'h00;
		end
		if (ctl.soft_rst) begin
			state_nxt = iog_pkg::HO_IDLE;
			cnt_nxt = 8'h00;
		end
	end

	// Prescaler restarts with each fresh interval so every step is a full 10 us
	assign pre_nxt = (state_nxt != iog_pkg::HO_HOLD || state_r != iog_pkg::HO_HOLD ||
		ctl.restart || tick) ? 12'h000 : pre_r + 12'h001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= iog_pkg::HO_IDLE;
			cnt_r <= 8'h00;
			pre_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			pre_r <= pre_nxt;
		end
	end

	assign ctl.active = (state_r == iog_pkg::HO_HOLD);
	assign ctl.deliver = (state_r == iog_pkg::HO_DELIVER) & req;
	assign ctl.count = cnt_r;

	// Checks on the timer
	AST_HOLD_AFTER_DELIVER: assert property (@(posedge clk) disable iff (rst)
		(state_r == iog_pkg::HO_DELIVER && !req && nonzero && !ctl.restart &&
		!ctl.zero_wr && !ctl.soft_rst) |=> ctl.active && cnt_r == $past(ctl.interval))
		else $error("interval did not start after delivery");
	AST_ZERO_STOPS: assert property (@(posedge clk) disable iff (rst)
		ctl.zero_wr |=> !ctl.active)
		else $error("zero interval left hold-off running");
	AST_RESTART: assert property (@(posedge clk) disable iff (rst)
		(ctl.restart && nonzero && !ctl.zero_wr && !ctl.soft_rst) |=> ctl.active &&
		pre_r == 12'h000 &&
		cnt_r == $past(ctl.interval))
		else $error("restart did not reload interval");
	AST_WITHHELD: assert property (@(posedge clk) disable iff (rst)
		ctl.active |=> !ctl.deliver)
		else $error("delivery straight out of hold-off");

	// Helper for the step check: cycles since the count last moved
	// A restart that reloads the same count still opens a fresh step, so it clears too
	logic [11:0] step_cyc_r;
	logic [7:0] cnt_seen_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_cyc_r <= 12'h000;
			cnt_seen_r <= 8'h00;
		end else begin
			cnt_seen_r <= cnt_r;
			step_cyc_r <= (!ctl.active || ctl.restart || cnt_r != cnt_seen_r) ? 12'h000 :
				step_cyc_r + 12'h001;
		end
	end
	AST_STEP: assert property (@(posedge clk) disable iff (rst)
		step_cyc_r <= iog_pkg::TICK_LAST + 12'h001)
		else $error("step longer than ten microseconds");
	COV_HOLD_END: cover property (@(posedge clk) disable iff (rst)
		ctl.active ##1 !ctl.active);
	COV_RESTART_RUNNING: cover property (@(posedge clk) disable iff (rst)
		ctl.active && ctl.restart);
endmodule // iog_holdoff

// ==== bench/iog_host_model.sv ====
// Host side of the interrupt pin: a pulled-up wired-OR input
`timescale 1ns/1ns
module iog_host_model (
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic pin_level
);
	// A released pin floats up to the pull-up, never to the last driven level
	assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule // iog_host_model

// ==== bench/interrupt_output_gate_test.sv ====
// Self-checking testbench of the interrupt output gate
`timescale 1ns/1ns
module interrupt_output_gate_test;
	logic clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic irq_line = 1'b0, power_event = 1'b0, irq_o, irq_oe, pin;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, r;
	int miscompares = 0, checks_done = 0, n;
	always #2 clk = ~clk;
	iog_top #(.DESIGN_ID(16'h1234), .DESIGN_REV(16'h0056)) DUT (.CLK(clk), .SYS_RST(sys_rst),
		.SOFT_RST(soft_rst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
		.RDATA(rdata), .IRQ_LINE(irq_line), .POWER_EVENT(power_event), .IRQ_O(irq_o),
		.IRQ_OE(irq_oe));
	iog_host_model host (.pin_o(irq_o), .pin_oe(irq_oe), .pin_level(pin));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// Data is registered, so it is picked up just after the edge that takes the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
	// Count cycles until the pin shows a level; a dead pin ends the run
	task automatic wait_pin(input logic want, input int lim, output int c);
		c = 0;
		while (pin !== want && c < lim) begin
			@(posedge clk);
			#1 c++;
		end
		if (pin !== want) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// Deliver, drop the line, raise it again and time the blocked stretch
	task automatic holdoff(input int steps);
		@(posedge clk) irq_line <= 1'b1;
		wait_pin(1'b0, 10, n);
		@(posedge clk) irq_line <= 1'b0;
		wait_pin(1'b1, 10, n);
		rd(iog_pkg::OFS_CFG, r);
		check(r[iog_pkg::POS_ACTIVE], 1'b1);
		@(posedge clk) irq_line <= 1'b1;
		wait_pin(1'b0, steps * 2600, n);
		check(n > steps * iog_pkg::TICK_CYC - 14 && n < steps * iog_pkg::TICK_CYC + 6, 1'b1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(iog_pkg::OFS_CFG, r);
		check(r, 32'h00000000);
		check(pin, 1'b1);
		wr(iog_pkg::OFS_IDENT, 32'hffffffff);
		rd(iog_pkg::OFS_IDENT, r);
		check(r, 32'h12340056);
		rd(8'h58, r);
		check(r, 32'h00000000);
		// Line up while the output is off: visible in status, not on the pin
		@(posedge clk) irq_line <= 1'b1;
		rd(iog_pkg::OFS_CFG, r);
		check(r, 32'h00001000);
		check(pin, 1'b1);
		@(posedge clk) irq_line <= 1'b0;
		wr(iog_pkg::OFS_CFG, 32'h01000100);
		holdoff(1);
		wr(iog_pkg::OFS_CFG, 32'h02000100);
		holdoff(2);
		// Restart late in an interval must push delivery a full step out
		wr(iog_pkg::OFS_CFG, 32'h01000100);
		@(posedge clk) irq_line <= 1'b0;
		wait_pin(1'b1, 10, n);
		@(posedge clk) irq_line <= 1'b1;
		repeat (2000) @(posedge clk);
		wr(iog_pkg::OFS_CFG, 32'h01004100);
		wait_pin(1'b0, 3000, n);
		check(n > 2400, 1'b1);
		// Zero interval frees the pending line at once
		@(posedge clk) irq_line <= 1'b0;
		wait_pin(1'b1, 10, n);
		@(posedge clk) irq_line <= 1'b1;
		repeat (100) @(posedge clk);
		wr(iog_pkg::OFS_CFG, 32'h00000100);
		wait_pin(1'b0, 8, n);
		check(pin, 1'b0);
		// Power event gets through a running interval
		wr(iog_pkg::OFS_CFG, 32'h01000100);
		@(posedge clk) irq_line <= 1'b0;
		wait_pin(1'b1, 10, n);
		@(posedge clk) power_event <= 1'b1;
		wait_pin(1'b0, 4, n);
		check(pin, 1'b0);
		@(posedge clk) power_event <= 1'b0;
		// Push-pull, active high: idle is driven low
		wr(iog_pkg::OFS_CFG, 32'h00000111);
		repeat (3) @(posedge clk);
		#1 check({irq_oe, pin}, 2'b10);
		@(posedge clk) irq_line <= 1'b1;
		wait_pin(1'b1, 8, n);
		wr(iog_pkg::OFS_CFG, 32'h00000101);
		wait_pin(1'b0, 8, n);
		check(irq_oe, 1'b1);
		// Open-drain ignores the polarity choice
		wr(iog_pkg::OFS_CFG, 32'h00000110);
		repeat (3) @(posedge clk);
		#1 check({irq_oe, pin}, 2'b10);
		wr(iog_pkg::OFS_CFG, 32'h01000111);
		@(posedge clk) soft_rst <= 1'b1;
		@(posedge clk) soft_rst <= 1'b0;
		rd(iog_pkg::OFS_CFG, r);
		check(r, 32'h00001011);
		@(posedge clk) sys_rst <= 1'b1;
		@(posedge clk) sys_rst <= 1'b0;
		rd(iog_pkg::OFS_CFG, r);
		check(r, 32'h00001000);
		give_verdict();
	end
endmodule // interrupt_output_gate_test
